// file: hw/cal_ctrl_consts.svh
// Register indices, field positions, reset values and counts of the calibration control bank.
`ifndef CAL_CTRL_CONSTS_SVH
`define CAL_CTRL_CONSTS_SVH
`define TS_CTRL_IDX 8'h3B
`define PE_IDX 8'h48
`define INSEL_IDX 8'h60
`define CALEN_IDX 8'h61
`define CALCFG_IDX 8'h62
`define CALSTAT_IDX 8'h6A
`define TS_CTRL_RST 8'h00
`define PE_RST 8'h00
`define INSEL_RST 8'h01
`define CALEN_RST 8'h01
`define CALCFG_RST 8'h01
`define TS_CTRL_MASK 8'h03
`define PE_MASK 8'h0F
`define INSEL_MASK 8'h13
`define CALEN_MASK 8'h01
`define CALCFG_MASK 8'h0F
`define TS_RECV_BIT 0
`define TS_ECL_BIT 1
`define PE_EXTRA_BIT 3
`define INSEL_SWAP_BIT 4
`define CALEN_BIT 0
`define SINGLE_A 2'h1
`define SINGLE_B 2'h2
`define SINGLE_BOTH 2'h3
`define LANE_COUNT 16
`define FG_CAL_CYCLES 16'h0010
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: hw/cal_ctrl_pkg.sv
// Types shared by the calibration control bank.
package cal_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_FORE = 2'h1,
        ST_BACK = 2'h2,
        ST_IDLE = 2'h3
    } cal_state_t;
    typedef struct packed {
        logic bgos_on;
        logic fos_on;
        logic bg_on;
        logic fg_on;
    } cal_opts_t;
    typedef struct packed {
        logic extra;
        logic [2:0] level;
    } lane_drive_t;
    typedef struct packed {
        logic a_from_b;
        logic b_from_b;
    } mux_route_t;
endpackage

// file: hw/adc_input_calibration_ctrl_regs.sv
// Calibration and input control register bank with its AXI4-Lite slave and calibration sequencer.
//
// Register access over AXI4-Lite was left to the implementer.
`include "cal_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_input_calibration_ctrl_regs
    import cal_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels.
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Operating mode from the mode selection logic.
    input wire logic operating_mode_single,
    // Timestamp receiver and lane controls.
    output logic timestamp_receiver_on,
    output logic timestamp_lowvolt_ecl_select,
    output lane_drive_t lane_drive [`LANE_COUNT],
    // Input multiplexer and calibration controls.
    output mux_route_t input_route,
    output logic cal_in_reset,
    output logic clk_div_reset,
    output logic cal_values_reset,
    output logic foreground_cal_active,
    output logic foreground_offset_active,
    output logic background_cal_active,
    output logic background_offset_active,
    output logic foreground_finished_flag
);
    localparam int FG_MAX = 19;

    logic [7:0] ts_r, ts_nxt, pe_r, pe_nxt, insel_r, insel_nxt;
    logic [7:0] calen_r, calen_nxt, calcfg_r, calcfg_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0] wr_idx_r, wr_idx_nxt, wr_dat_r, wr_dat_nxt;
    logic wr_en_r, wr_en_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] rd_idx, status;
    logic rd_hit;

    cal_state_t state_r, state_nxt;
    cal_opts_t opts_r, opts_nxt;
    mux_route_t route_r, route_nxt;
    logic prev_en_r, prev_en_nxt, done_r, done_nxt, vrst_r, vrst_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic cal_on, cal_rise;

    assign awready = !aw_got_r && !bvalid_r && !wr_en_r;
    assign wready = !w_got_r && !bvalid_r && !wr_en_r;
    assign arready = !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign rd_idx = araddr[9:2];
    assign status = {5'h00, state_r == ST_BACK, state_r == ST_FORE, done_r};

    always_comb
    begin
        rd_hit = 1'b1;
        case (rd_idx)
            `TS_CTRL_IDX: rdata_nxt = {24'h000000, ts_r};
            `PE_IDX: rdata_nxt = {24'h000000, pe_r};
            `INSEL_IDX: rdata_nxt = {24'h000000, insel_r};
            `CALEN_IDX: rdata_nxt = {24'h000000, calen_r};
            `CALCFG_IDX: rdata_nxt = {24'h000000, calcfg_r};
            `CALSTAT_IDX: rdata_nxt = {24'h000000, status};
            default:
            begin
                rdata_nxt = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
        rresp_nxt = rresp_r;
        rvalid_nxt = rvalid_r;
        if (rvalid_r)
        begin
            rdata_nxt = rdata_r;
            if (rready)
            begin
                rvalid_nxt = 1'b0;
            end
        end
        else if (arvalid)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else
        begin
            rdata_nxt = rdata_r;
        end
    end

    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        wr_idx_nxt = wr_idx_r;
        wr_dat_nxt = wr_dat_r;
        wr_en_nxt = 1'b0;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ts_nxt = ts_r;
        pe_nxt = pe_r;
        insel_nxt = insel_r;
        calen_nxt = calen_r;
        calcfg_nxt = calcfg_r;
        if (awvalid && awready)
        begin
            aw_got_nxt = 1'b1;
            wr_idx_nxt = awaddr[9:2];
        end
        if (wvalid && wready)
        begin
            w_got_nxt = 1'b1;
            wr_dat_nxt = wstrb[0] ? wdata[7:0] : 8'h00;
            wr_en_nxt = 1'b0;
        end
        if (aw_got_r && w_got_r)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            wr_en_nxt = 1'b1;
        end
        if (wr_en_r)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = `RESP_OKAY;
            case (wr_idx_r)
                `TS_CTRL_IDX: ts_nxt = wr_dat_r & `TS_CTRL_MASK;
                `PE_IDX: pe_nxt = wr_dat_r & `PE_MASK;
                `INSEL_IDX: insel_nxt = wr_dat_r & `INSEL_MASK;
                `CALEN_IDX: calen_nxt = wr_dat_r & `CALEN_MASK;
                `CALCFG_IDX: calcfg_nxt = wr_dat_r & `CALCFG_MASK;
                `CALSTAT_IDX: bresp_nxt = `RESP_OKAY;
                default: bresp_nxt = `RESP_SLVERR;
            endcase
        end
        else if (bvalid_r && bready)
        begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ts_r <= `TS_CTRL_RST;
            pe_r <= `PE_RST;
            insel_r <= `INSEL_RST;
            calen_r <= `CALEN_RST;
            calcfg_r <= `CALCFG_RST;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wr_idx_r <= 8'h00;
            wr_dat_r <= 8'h00;
            wr_en_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            ts_r <= ts_nxt;
            pe_r <= pe_nxt;
            insel_r <= insel_nxt;
            calen_r <= calen_nxt;
            calcfg_r <= calcfg_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            wr_idx_r <= wr_idx_nxt;
            wr_dat_r <= wr_dat_nxt;
            wr_en_r <= wr_en_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign timestamp_receiver_on = ts_r[`TS_RECV_BIT];
    assign timestamp_lowvolt_ecl_select = ts_r[`TS_ECL_BIT];

    // Every lane receives the same drive setting.
    for (genvar i = 0; i < `LANE_COUNT; i++)
    begin : g_lane
        assign lane_drive[i] = '{extra: pe_r[`PE_EXTRA_BIT], level: pe_r[2:0]};
    end

    assign cal_on = calen_r[`CALEN_BIT];
    assign cal_rise = cal_on && !prev_en_r;
    assign cal_in_reset = !cal_on;
    assign clk_div_reset = !cal_on;
    assign input_route = route_r;
    assign cal_values_reset = vrst_r;
    assign foreground_cal_active = state_r == ST_FORE;
    assign foreground_offset_active = (state_r == ST_FORE) && opts_r.fos_on;
    assign background_cal_active = state_r == ST_BACK;
    assign background_offset_active = (state_r == ST_BACK) && opts_r.bgos_on;
    assign foreground_finished_flag = done_r;

    always_comb
    begin
        state_nxt = state_r;
        opts_nxt = opts_r;
        route_nxt = route_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        vrst_nxt = 1'b0;
        prev_en_nxt = cal_on;
        if (!cal_on)
        begin
            state_nxt = ST_HOLD;
            done_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                ST_HOLD:
                begin
                    if (cal_rise)
                    begin
                        opts_nxt = cal_opts_t'(calcfg_r[3:0]);
                        vrst_nxt = 1'b1;
                        if (operating_mode_single)
                        begin
                            case (insel_r[1:0])
                                `SINGLE_B: route_nxt = '{a_from_b: 1'b1, b_from_b: 1'b1};
                                `SINGLE_BOTH: route_nxt = '{a_from_b: 1'b0, b_from_b: 1'b1};
                                default: route_nxt = '{a_from_b: 1'b0, b_from_b: 1'b0};
                            endcase
                        end
                        else
                        begin
                            route_nxt.a_from_b = insel_r[`INSEL_SWAP_BIT];
                            route_nxt.b_from_b = !insel_r[`INSEL_SWAP_BIT];
                        end
                        if (calcfg_r[0])
                        begin
                            state_nxt = ST_FORE;
                            cnt_nxt = `FG_CAL_CYCLES - 16'h0001;
                        end
                        else
                        begin
                            done_nxt = 1'b1;
                            state_nxt = calcfg_r[1] ? ST_BACK : ST_IDLE;
                        end
                    end
                end
                ST_FORE:
                begin
                    if (cnt_r == 16'h0000)
                    begin
                        done_nxt = 1'b1;
                        state_nxt = opts_r.bg_on ? ST_BACK : ST_IDLE;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                ST_BACK: state_nxt = ST_BACK;
                ST_IDLE: state_nxt = ST_IDLE;
                default: state_nxt = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_HOLD;
            opts_r <= cal_opts_t'(4'h1);
            route_r <= '{a_from_b: 1'b0, b_from_b: 1'b0};
            cnt_r <= 16'h0000;
            done_r <= 1'b0;
            vrst_r <= 1'b0;
            prev_en_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            opts_r <= opts_nxt;
            route_r <= route_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            vrst_r <= vrst_nxt;
            prev_en_r <= prev_en_nxt;
        end
    end

    AST_TS_CTRL: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en_r && wr_idx_r == `TS_CTRL_IDX |=>
        timestamp_receiver_on == $past(wr_dat_r[0]) && timestamp_lowvolt_ecl_select == $past(wr_dat_r[1]))
        else $error("timestamp control not applied");
    AST_LANES: assert property (@(posedge aclk) disable iff (!aresetn)
        lane_drive[`LANE_COUNT-1] == lane_drive[0] && lane_drive[0].level == pe_r[2:0])
        else $error("lane drive differs between lanes");
    AST_EXTRA: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en_r && wr_idx_r == `PE_IDX |=> lane_drive[5].extra == $past(wr_dat_r[3]))
        else $error("boost bit not applied");
    AST_ROUTE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !cal_rise |=> $stable(input_route))
        else $error("input route changed without calibration start");
    AST_SWAP: assert property (@(posedge aclk) disable iff (!aresetn)
        cal_rise && state_r == ST_HOLD && !operating_mode_single |=>
        input_route.a_from_b == $past(insel_r[4]) && input_route.b_from_b != $past(insel_r[4]))
        else $error("dual channel route wrong");
    AST_SINGLE: assert property (@(posedge aclk) disable iff (!aresetn)
        cal_rise && state_r == ST_HOLD && operating_mode_single && insel_r[1:0] == 2'h2 |=>
        input_route == 2'h3)
        else $error("single channel route wrong");
    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !cal_on |=> state_r == ST_HOLD && !foreground_finished_flag)
        else $error("calibration not held in reset");
    AST_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en_r && wr_idx_r == `CALEN_IDX && !wr_dat_r[0] |=> clk_div_reset && cal_in_reset)
        else $error("dividers not reset");
    AST_FOREGROUND_FINISHED_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_HOLD && cal_rise && calcfg_r[0] |->
        ##[1:FG_MAX] (foreground_finished_flag || !cal_on))
        else $error("foreground done too late");
    AST_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_HOLD && cal_rise && !calcfg_r[0] |=> done_r && vrst_r && !foreground_cal_active)
        else $error("skipped foreground not flagged");
    AST_BGOS: assert property (@(posedge aclk) disable iff (!aresetn)
        background_offset_active |-> background_cal_active && opts_r.bg_on)
        else $error("background offset without background");
endmodule
`default_nettype wire

// file: bench/adc_input_calibration_ctrl_regs_bench.sv
// Self-checking bench for the calibration control register bank.
`include "cal_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_input_calibration_ctrl_regs_bench
    import cal_ctrl_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic operating_mode_single = 1'b0;
    logic ts_on;
    logic ts_ecl;
    lane_drive_t lane_drive [`LANE_COUNT];
    mux_route_t input_route;
    logic cal_in_reset;
    logic clk_div_reset;
    logic cal_values_reset;
    logic fg_act;
    logic fos_act;
    logic bg_act;
    logic bos_act;
    logic fg_flag;
    integer seed;
    int n_fail = 0;
    int check_count = 0;

    adc_input_calibration_ctrl_regs dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .operating_mode_single(operating_mode_single),
        .timestamp_receiver_on(ts_on), .timestamp_lowvolt_ecl_select(ts_ecl),
        .lane_drive(lane_drive), .input_route(input_route), .cal_in_reset(cal_in_reset),
        .clk_div_reset(clk_div_reset), .cal_values_reset(cal_values_reset),
        .foreground_cal_active(fg_act), .foreground_offset_active(fos_act),
        .background_cal_active(bg_act), .background_offset_active(bos_act),
        .foreground_finished_flag(fg_flag)
    );

    always #12.5 aclk = ~aclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Write one register word; address and data are released as each is taken.
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        int n;
        logic aw_done;
        logic w_done;
        logic fin;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        fin = 1'b0;
        @(posedge aclk);
        awaddr <= {22'h0, idx, 2'b00};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!fin && n < 40)
        begin
            @(posedge aclk);
            n++;
            fin = aw_done && w_done && bvalid;
            if (!aw_done && awready)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        resp = bresp;
        bready <= 1'b0;
        check({31'h0, fin}, 32'h1, "write answer");
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ar_done;
        logic fin;
        n = 0;
        ar_done = 1'b0;
        fin = 1'b0;
        @(posedge aclk);
        araddr <= {22'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!fin && n < 40)
        begin
            @(posedge aclk);
            n++;
            fin = ar_done && rvalid;
            if (!ar_done && arready)
            begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        check({31'h0, fin}, 32'h1, "read answer");
    endtask

    // Channel sources expected after a calibration start.
    function automatic logic [1:0] route_of(input logic [7:0] v, input logic single);
        if (!single)
            return v[`INSEL_SWAP_BIT] ? 2'b10 : 2'b01;
        case (v[1:0])
            `SINGLE_B: return 2'b11;
            `SINGLE_BOTH: return 2'b01;
            default: return 2'b00;
        endcase
    endfunction

    task automatic wait_flag(output int n);
        n = 0;
        while (fg_flag !== 1'b1 && n < 60)
        begin
            @(negedge aclk);
            n++;
        end
    endtask

    initial
    begin
        #500000;
        n_fail++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end

    initial
    begin
        logic [7:0] idxs [5];
        logic [7:0] rsts [5];
        logic [31:0] d;
        logic [31:0] q;
        logic [3:0] s;
        logic [7:0] e;
        logic [7:0] v;
        logic [3:0] cfg;
        logic [1:0] resp;
        logic [1:0] prev;
        logic single;
        int n;
        idxs = '{`TS_CTRL_IDX, `PE_IDX, `INSEL_IDX, `CALEN_IDX, `CALCFG_IDX};
        rsts = '{`TS_CTRL_RST, `PE_RST, `INSEL_RST, `CALEN_RST, `CALCFG_RST};
        seed = 32'h3F93;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            rd(idxs[i], q, resp);
            check(q, {24'h0, rsts[i]}, "reset value");
        end
        wait_flag(n);
        check({31'h0, fg_flag}, 32'h1, "auto calibration done");
        rd(`CALSTAT_IDX, q, resp);
        check({31'h0, q[0]}, 32'h1, "status done bit");
        prev = route_of(`INSEL_RST, 1'b0);
        check({30'h0, input_route}, {30'h0, prev}, "reset route");
        for (int i = 0; i < 24; i++)
        begin
            d = $random(seed);
            s = $random(seed);
            e = s[0] ? d[7:0] & (i[0] ? `PE_MASK : `TS_CTRL_MASK) : 8'h00;
            wr(i[0] ? `PE_IDX : `TS_CTRL_IDX, d, s, resp);
            rd(i[0] ? `PE_IDX : `TS_CTRL_IDX, q, resp);
            check(q, {24'h0, e}, "readback");
            @(negedge aclk);
            if (i[0])
            begin
                for (int k = 0; k < `LANE_COUNT; k++)
                    check({28'h0, lane_drive[k]}, {28'h0, e[3:0]}, "lane drive");
            end
            else
                check({30'h0, ts_ecl, ts_on}, {30'h0, e[1:0]}, "timestamp");
        end
        wr(8'h70, 32'hFF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped write");
        rd(8'h70, q, resp);
        check(q, 32'h0, "unmapped read data");
        check({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped read");
        wr(`CALSTAT_IDX, 32'hFF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, `RESP_OKAY}, "status write");
        for (int c = 0; c < 32; c++)
        begin
            cfg = c[3:0];
            single = c[4];
            wr(`CALEN_IDX, 32'h0, 4'h1, resp);
            repeat (2) @(negedge aclk);
            check({30'h0, cal_in_reset, clk_div_reset}, 32'h3, "hold in reset");
            check({29'h0, fg_flag, fg_act, bg_act}, 32'h0, "held idle");
            v = $random(seed);
            wr(`INSEL_IDX, {24'h0, v}, 4'hF, resp);
            wr(`CALCFG_IDX, {28'h0, cfg}, 4'hF, resp);
            operating_mode_single <= single;
            check({30'h0, input_route}, {30'h0, prev}, "route before start");
            wr(`CALEN_IDX, 32'h1, 4'h1, resp);
            n = 0;
            while (cal_values_reset !== 1'b1 && n < 10)
            begin
                @(negedge aclk);
                n++;
            end
            check({31'h0, cal_values_reset}, 32'h1, "values reset");
            check({30'h0, fg_act, fos_act}, {30'h0, cfg[0], cfg[0] & cfg[2]}, "fg");
            wait_flag(n);
            check({31'h0, cfg[0] ? (n >= 15 && n <= 17) : (n <= 1)}, 32'h1, "fg time");
            @(negedge aclk);
            check({30'h0, bg_act, bos_act}, {30'h0, cfg[1], cfg[1] & cfg[3]}, "bg");
            check({31'h0, fg_act}, 32'h0, "fg over");
            prev = route_of(v, single);
            check({30'h0, input_route}, {30'h0, prev}, "route");
            wr(`CALCFG_IDX, {28'h0, ~cfg}, 4'hF, resp);
            wr(`INSEL_IDX, {24'h0, v ^ 8'h13}, 4'hF, resp);
            @(negedge aclk);
            check({30'h0, bg_act, bos_act}, {30'h0, cfg[1], cfg[1] & cfg[3]}, "latched");
            check({30'h0, input_route}, {30'h0, prev}, "route held");
        end
        test_done();
    end
endmodule
`default_nettype wire
